// [rtl/acd_clock_dividers.sv]
// Auxiliary clock dividers with their AXI4-Lite control registers
//
// Implementation choice: the AXI4-Lite slave port.
module acd_clock_dividers import acd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic adc_rate_tick,
  input wire logic dac_divider_tick,
  output logic converter_clock_tick,
  output logic adc_modulator_tick,
  output logic dac_clock_tick,
  output logic class_d_tick,
  output logic speaker_switch,
  output logic dc_servo_tick,
  output logic housekeeping_tick,
  output logic adc_oversample_high,
  output logic clocking_mode_select
);

  typedef struct packed {
    logic [2:0] cd_code;
    logic osr;
    logic conv_en;
    logic [3:0] dcs_code;
    logic mode;
    logic [5:0] hk_code;
    logic dac_q;
    logic [NUM_DIV-1:0][7:0] acc;
    logic [NUM_DIV-1:0] tick;
    logic spk;
    logic [1:0] adc_cnt;
    logic adc_tick;
    logic [1:0] dac_cnt;
    logic dac_tick;
    logic conv_tick;
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acd_state_type;

  acd_state_type s_q;
  acd_state_type s_d;
  logic [2:0] cd_eff;
  logic [3:0] dcs_eff;
  logic [5:0] hk_eff;
  logic dq_eff;
  logic [NUM_DIV-1:0][7:0] p2;
  // Ratios are kept in half steps so 1.5, 2.5 and 5.5 stay exact
  function automatic logic [7:0] cd_halves(input logic [2:0] code);
    logic [7:0] h;
    unique case (code)
      3'h0: h = 8'h02;
      3'h1: h = 8'h04;
      3'h2: h = 8'h06;
      3'h3: h = 8'h08;
      3'h4: h = 8'h0c;
      3'h5: h = 8'h10;
      3'h6: h = 8'h18;
      3'h7: h = 8'h20;
    endcase
    return h;
  endfunction : cd_halves
  // Undefined codes fall back to the slowest ratio
  function automatic logic [7:0] dcs_halves(input logic [3:0] code);
    logic [7:0] h;
    unique case (code)
      4'h0: h = 8'h02;
      4'h1: h = 8'h03;
      4'h2: h = 8'h04;
      4'h3: h = 8'h05;
      4'h4: h = 8'h06;
      4'h5: h = 8'h08;
      4'h6: h = 8'h0b;
      4'h7: h = 8'h0c;
      default: h = 8'h10;
    endcase
    return h;
  endfunction : dcs_halves
  function automatic acd_reg_type reg_sel(input logic [11:0] addr);
    acd_reg_type r;
    r = REG_NONE;
    if (addr[1:0] == 2'h0) begin
      if (addr[11:2] == IDX_CTRL_ONE) begin
        r = REG_ONE;
      end else if (addr[11:2] == IDX_ADC_CONTROL) begin
        r = REG_ADC;
      end else if (addr[11:2] == IDX_CTRL_THREE) begin
        r = REG_THREE;
      end else if (addr[11:2] == IDX_CTRL_FOUR) begin
        r = REG_FOUR;
      end
    end
    return r;
  endfunction : reg_sel
  function automatic logic [15:0] reg_read(input acd_reg_type sel, input acd_state_type s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (sel)
      REG_ONE: v[CD_LSB +: 3] = s.cd_code;
      REG_ADC: v[ADC_OSR_BIT] = s.osr;
      REG_THREE: begin
        v[CONV_EN_BIT] = s.conv_en;
        v[DCS_LSB +: 4] = s.dcs_code;
      end
      REG_FOUR: begin
        v[MODE_BIT] = s.mode;
        v[HK_LSB +: 6] = s.hk_code;
        v[DAC_Q_BIT] = s.dac_q;
      end
      REG_NONE: v = 16'h0000;
    endcase
    return v;
  endfunction : reg_read

  assign cd_eff = (s_q.mode == MODE_MANUAL) ? s_q.cd_code : AUTO_CD_CODE;
  assign dcs_eff = (s_q.mode == MODE_MANUAL) ? s_q.dcs_code : AUTO_DCS_CODE;
  assign hk_eff = (s_q.mode == MODE_MANUAL) ? s_q.hk_code : AUTO_HK_CODE;
  assign dq_eff = (s_q.mode == MODE_MANUAL) ? s_q.dac_q : AUTO_DAC_Q;
  assign p2[CH_CD] = cd_halves(cd_eff);
  assign p2[CH_DCS] = dcs_halves(dcs_eff);
  assign p2[CH_HK] = {1'b0, hk_eff, 1'b0} + 8'h02;

  // Ready drops with ce so no beat is taken while state is frozen
  assign s_axi_awready = ce & ~s_q.aw_have;
  assign s_axi_wready = ce & ~s_q.w_have;
  assign s_axi_arready = ce & ~s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign converter_clock_tick = s_q.conv_tick;
  assign adc_modulator_tick = s_q.adc_tick;
  assign dac_clock_tick = s_q.dac_tick;
  assign class_d_tick = s_q.tick[CH_CD];
  assign speaker_switch = s_q.spk;
  assign dc_servo_tick = s_q.tick[CH_DCS];
  assign housekeeping_tick = s_q.tick[CH_HK];
  assign adc_oversample_high = s_q.osr;
  assign clocking_mode_select = s_q.mode;

  always_comb begin
    logic [7:0] sum;
    logic [7:0] rem;
    logic [15:0] wv;
    acd_reg_type wsel;
    acd_reg_type rsel;
    sum = 8'h00;
    rem = 8'h00;
    wv = 16'h0000;
    wsel = reg_sel(s_q.aw_addr);
    rsel = reg_sel(s_axi_araddr);
    s_d = s_q;
    // Accumulator step of two halves per cycle gives the average ratio
    for (int i = 0; i < NUM_DIV; i++) begin
      sum = s_q.acc[i] + DIV_STEP;
      rem = sum - p2[i];
      if (sum >= p2[i]) begin
        s_d.tick[i] = 1'b1;
        // Clamp after a ratio change so the next interval is clean
        s_d.acc[i] = (rem >= p2[i]) ? 8'h00 : rem;
      end else begin
        s_d.tick[i] = 1'b0;
        s_d.acc[i] = sum;
      end
    end
    if (s_d.tick[CH_CD]) begin
      s_d.spk = ~s_q.spk;
    end
    s_d.conv_tick = s_q.conv_en;
    s_d.adc_tick = 1'b0;
    if (s_q.conv_en && adc_rate_tick) begin
      if (s_q.adc_cnt >= (s_q.osr ? ADC_PHASE_128 : ADC_PHASE_64)) begin
        s_d.adc_tick = 1'b1;
        s_d.adc_cnt = 2'h0;
      end else begin
        s_d.adc_cnt = 2'(s_q.adc_cnt + 2'h1);
      end
    end
    s_d.dac_tick = 1'b0;
    if (s_q.conv_en && dac_divider_tick) begin
      if (!dq_eff || s_q.dac_cnt >= DAC_PHASE_Q) begin
        s_d.dac_tick = 1'b1;
        s_d.dac_cnt = 2'h0;
      end else begin
        s_d.dac_cnt = 2'(s_q.dac_cnt + 2'h1);
      end
    end
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      wv = reg_read(wsel, s_q);
      if (s_q.w_strb[0]) begin
        wv[7:0] = s_q.w_data[7:0];
      end
      if (s_q.w_strb[1]) begin
        wv[15:8] = s_q.w_data[15:8];
      end
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (wsel)
        REG_ONE: s_d.cd_code = wv[CD_LSB +: 3];
        REG_ADC: s_d.osr = wv[ADC_OSR_BIT];
        REG_THREE: begin
          s_d.conv_en = wv[CONV_EN_BIT];
          s_d.dcs_code = wv[DCS_LSB +: 4];
        end
        REG_FOUR: begin
          s_d.mode = wv[MODE_BIT];
          s_d.hk_code = wv[HK_LSB +: 6];
          s_d.dac_q = wv[DAC_Q_BIT];
        end
        REG_NONE: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = {16'h0000, reg_read(rsel, s_q)};
      s_d.rresp = (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.cd_code <= CD_RST;
      s_q.osr <= OSR_RST;
      s_q.conv_en <= CONV_EN_RST;
      s_q.dcs_code <= DCS_RST;
      s_q.mode <= MODE_RST;
      s_q.hk_code <= HK_RST;
      s_q.dac_q <= DAC_Q_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Period checkers, one per divider channel
  for (genvar g = 0; g < NUM_DIV; g++) begin : g_chk
    logic [7:0] gap_q;
    logic [7:0] p2_last_q;
    logic chg_q;
    logic clean_q;
    always_ff @(posedge clk) begin
      if (reset) begin
        gap_q <= 8'h00;
        p2_last_q <= 8'h00;
        chg_q <= 1'b1;
        clean_q <= 1'b0;
      end else if (ce) begin
        if (s_q.tick[g]) begin
          gap_q <= 8'h00;
          p2_last_q <= p2[g];
          chg_q <= 1'b0;
          clean_q <= !chg_q && (p2[g] == p2_last_q);
        end else begin
          gap_q <= gap_q + 8'h01;
          if (p2[g] != p2_last_q) begin
            chg_q <= 1'b1;
          end
        end
      end
    end
    AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (reset)
      (ce && s_q.tick[g] && clean_q && !chg_q && p2[g] == p2_last_q) |->
      (gap_q + 8'h01 == (p2[g] >> 1) || gap_q + 8'h01 == ((p2[g] + 8'h01) >> 1)))
      else $error("divider period off ratio");
  end
  sequence s_adc_hit;
    ce && s_q.conv_en && adc_rate_tick &&
      s_q.adc_cnt >= (s_q.osr ? ADC_PHASE_128 : ADC_PHASE_64);
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  AST_ADC_OSR: assert property (@(posedge clk) disable iff (reset)
    s_adc_hit |=> s_q.adc_tick)
    else $error("adc oversample tick missing");
  AST_SPEAKER_HALF: assert property (@(posedge clk) disable iff (reset)
    $past(ce) |-> ((s_q.spk != $past(s_q.spk)) == s_q.tick[CH_CD]))
    else $error("speaker switch not halving class d");
  // Checked on the half-step periods the accumulators really use
  AST_MANUAL_SRC: assert property (@(posedge clk) disable iff (reset)
    (s_q.mode == MODE_MANUAL) |-> (p2[CH_CD] == cd_halves(s_q.cd_code) &&
    p2[CH_DCS] == dcs_halves(s_q.dcs_code) &&
    p2[CH_HK] == ({2'h0, s_q.hk_code} + 8'h01) << 1))
    else $error("manual mode not using fields");
  AST_AUTO_SRC: assert property (@(posedge clk) disable iff (reset)
    (s_q.mode == MODE_AUTO) |-> (p2[CH_CD] == cd_halves(AUTO_CD_CODE) &&
    p2[CH_DCS] == dcs_halves(AUTO_DCS_CODE) &&
    p2[CH_HK] == ({2'h0, AUTO_HK_CODE} + 8'h01) << 1 && dq_eff))
    else $error("auto mode using fields");
  AST_CONV_GATE: assert property (@(posedge clk) disable iff (reset)
    (ce && !s_q.conv_en) |=> (!s_q.adc_tick && !s_q.dac_tick && !s_q.conv_tick))
    else $error("converter clock not gated");
  AST_DAC_QUARTER: assert property (@(posedge clk) disable iff (reset)
    (ce && s_q.conv_en && dac_divider_tick) |=>
    (s_q.dac_tick == (!$past(dq_eff) || $past(s_q.dac_cnt) >= DAC_PHASE_Q)))
    else $error("dac quarter divide wrong");
  AST_MODE_RESET: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> (s_q.mode == MODE_MANUAL && s_q.dac_q && s_q.osr && !s_q.conv_en))
    else $error("wrong reset values");
  AST_B_HOLD: assert property (@(posedge clk) disable iff (reset)
    s_b_wait |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");
  AST_R_HOLD: assert property (@(posedge clk) disable iff (reset)
    s_r_wait |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped");
endmodule : acd_clock_dividers

// [rtl/acd_pkg.sv]
// Register map, field layout, reset values and divider constants
package acd_pkg;

  localparam logic [9:0] IDX_CTRL_ONE = 10'h006;
  localparam logic [9:0] IDX_ADC_CONTROL = 10'h00e;
  localparam logic [9:0] IDX_CTRL_THREE = 10'h041;
  localparam logic [9:0] IDX_CTRL_FOUR = 10'h042;

  localparam int CD_LSB = 6;
  localparam int ADC_OSR_BIT = 9;
  localparam int CONV_EN_BIT = 0;
  localparam int DCS_LSB = 10;
  localparam int MODE_BIT = 0;
  localparam int HK_LSB = 1;
  localparam int DAC_Q_BIT = 9;

  localparam logic [2:0] CD_RST = 3'h7;
  localparam logic OSR_RST = 1'h1;
  localparam logic CONV_EN_RST = 1'h0;
  localparam logic [3:0] DCS_RST = 4'h8;
  localparam logic MODE_RST = 1'h1;
  localparam logic [5:0] HK_RST = 6'h2f;
  localparam logic DAC_Q_RST = 1'h1;

  localparam logic MODE_AUTO = 1'h0;
  localparam logic MODE_MANUAL = 1'h1;

  localparam logic [2:0] AUTO_CD_CODE = 3'h7;
  localparam logic [3:0] AUTO_DCS_CODE = 4'h8;
  localparam logic [5:0] AUTO_HK_CODE = 6'h2f;
  localparam logic AUTO_DAC_Q = 1'h1;

  localparam logic [1:0] ADC_PHASE_128 = 2'h1;
  localparam logic [1:0] ADC_PHASE_64 = 2'h3;
  localparam logic [1:0] DAC_PHASE_Q = 2'h3;

  localparam logic [7:0] DIV_STEP = 8'h02;
  localparam int NUM_DIV = 3;
  localparam int CH_CD = 0;
  localparam int CH_DCS = 1;
  localparam int CH_HK = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_ONE,
    REG_ADC,
    REG_THREE,
    REG_FOUR
  } acd_reg_type;

endpackage : acd_pkg

// [test/acd_clock_dividers_bench.sv]
// Self-checking bench for the auxiliary clock dividers
module acd_clock_dividers_bench import acd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, reset, ce;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic adc_rate_tick, dac_divider_tick, converter_clock_tick, adc_modulator_tick;
  logic dac_clock_tick, class_d_tick, speaker_switch, dc_servo_tick, housekeeping_tick;
  logic adc_oversample_high, clocking_mode_select, spk_prev;
  int fail_count = 0;
  int check_count = 0;
  int cnt [6] = '{default: 0};

  acd_clock_dividers DUT (.clk, .reset, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .adc_rate_tick, .dac_divider_tick, .converter_clock_tick,
    .adc_modulator_tick, .dac_clock_tick, .class_d_tick, .speaker_switch, .dc_servo_tick,
    .housekeeping_tick, .adc_oversample_high, .clocking_mode_select);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulse tallies; speaker counts rising edges only
  always @(posedge clk) begin
    spk_prev <= speaker_switch;
    if (class_d_tick === 1'b1) cnt[0]++;
    if (dc_servo_tick === 1'b1) cnt[1]++;
    if (housekeeping_tick === 1'b1) cnt[2]++;
    if (adc_modulator_tick === 1'b1) cnt[3]++;
    if (dac_clock_tick === 1'b1) cnt[4]++;
    if (speaker_switch === 1'b1 && spk_prev === 1'b0) cnt[5]++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic guard(inout int n);
    n = n + 1;
    if (n > 200) begin
      check("wait bound", 32'h1, 32'h0);
      test_done();
    end
  endtask : guard

  function automatic logic [11:0] ad(input logic [9:0] idx);
    return {idx, 2'h0};
  endfunction : ad

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] strb,
      input logic [1:0] er);
    bit aw_done;
    bit w_done;
    int n;
    aw_done = 0;
    w_done = 0;
    n = 0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      guard(n);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      guard(n);
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er,
      input string what);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      guard(n);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      guard(n);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(what, s_axi_rdata, exp);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  // Settle past the irregular first interval, then count whole periods
  task automatic win(input int k, input int len, input int exp, input string what);
    int s;
    repeat (70) @(negedge clk);
    s = cnt[k];
    repeat (len) @(negedge clk);
    check(what, cnt[k] - s, exp);
  endtask : win

  task automatic pulses(input int exp_mod, input int exp_dac);
    int s3;
    int s4;
    @(negedge clk);
    s3 = cnt[3];
    s4 = cnt[4];
    repeat (8) begin
      @(posedge clk);
      adc_rate_tick <= 1'b1;
      dac_divider_tick <= 1'b1;
      @(posedge clk);
      adc_rate_tick <= 1'b0;
      dac_divider_tick <= 1'b0;
    end
    repeat (4) @(negedge clk);
    check("modulator ticks", cnt[3] - s3, exp_mod);
    check("dac ticks", cnt[4] - s4, exp_dac);
  endtask : pulses

  task automatic t_reset();
    rd(ad(IDX_CTRL_ONE), 32'h1c0, RESP_OKAY, "ctrl one");
    rd(ad(IDX_ADC_CONTROL), 32'h200, RESP_OKAY, "adc control");
    rd(ad(IDX_CTRL_THREE), 32'h2000, RESP_OKAY, "ctrl three");
    rd(ad(IDX_CTRL_FOUR), 32'h25f, RESP_OKAY, "ctrl four");
    check("oversample", adc_oversample_high, 1'b1);
    check("mode", clocking_mode_select, 1'b1);
    check("conv clock", converter_clock_tick, 1'b0);
    win(0, 256, 16, "class d default");
    win(1, 128, 16, "servo default");
    win(2, 384, 8, "housekeeping default");
  endtask : t_reset

  task automatic t_gate();
    pulses(0, 0);
    wr(ad(IDX_CTRL_THREE), 32'h2001, 4'h3, RESP_OKAY);
    @(negedge clk);
    check("conv clock", converter_clock_tick, 1'b1);
    pulses(4, 2);
    wr(ad(IDX_ADC_CONTROL), 32'h0, 4'h3, RESP_OKAY);
    @(negedge clk);
    check("oversample", adc_oversample_high, 1'b0);
    pulses(2, 2);
    wr(ad(IDX_CTRL_FOUR), 32'h05f, 4'h3, RESP_OKAY);
    pulses(2, 8);
  endtask : t_gate

  task automatic t_div();
    int cd [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    int dcs [9] = '{2, 3, 4, 5, 6, 8, 11, 12, 16};
    int hk [3] = '{0, 1, 63};
    // No speaker stage sits behind this bench, so the code may move freely
    for (int c = 0; c < 8; c++) begin
      wr(ad(IDX_CTRL_ONE), 32'(c) << 6, 4'h3, RESP_OKAY);
      win(0, 16 * cd[c], 16, "class d ratio");
      win(5, 32 * cd[c], 16, "speaker toggles");
    end
    // Half ratios span two output periods per full pattern
    for (int c = 0; c < 9; c++) begin
      wr(ad(IDX_CTRL_THREE), (32'(c) << 10) | 32'h1, 4'h3, RESP_OKAY);
      win(1, 8 * dcs[c], 16, "servo ratio");
    end
    for (int i = 0; i < 3; i++) begin
      wr(ad(IDX_CTRL_FOUR), (32'(hk[i]) << 1) | 32'h1, 4'h3, RESP_OKAY);
      win(2, 8 * (hk[i] + 1), 8, "housekeeping ratio");
    end
  endtask : t_div

  task automatic t_auto();
    wr(ad(IDX_CTRL_FOUR), 32'h0, 4'h3, RESP_OKAY);
    wr(ad(IDX_CTRL_ONE), 32'h0, 4'h3, RESP_OKAY);
    wr(ad(IDX_CTRL_THREE), 32'h1, 4'h3, RESP_OKAY);
    wr(ad(IDX_ADC_CONTROL), 32'h200, 4'h3, RESP_OKAY);
    @(negedge clk);
    check("mode", clocking_mode_select, 1'b0);
    win(0, 256, 16, "auto class d");
    win(1, 128, 16, "auto servo");
    win(2, 384, 8, "auto housekeeping");
    pulses(4, 2);
    // Software puts the rate fields back to their defaults
    wr(ad(IDX_CTRL_FOUR), 32'h25f, 4'h3, RESP_OKAY);
    wr(ad(IDX_CTRL_ONE), 32'h1c0, 4'h3, RESP_OKAY);
    wr(ad(IDX_CTRL_THREE), 32'h2001, 4'h3, RESP_OKAY);
    rd(ad(IDX_CTRL_FOUR), 32'h25f, RESP_OKAY, "ctrl four back");
  endtask : t_auto

  task automatic t_bus();
    rd(12'h400, 32'h0, RESP_SLVERR, "unmapped read");
    rd(12'h01a, 32'h0, RESP_SLVERR, "misaligned read");
    wr(12'h400, 32'hffff, 4'h3, RESP_SLVERR);
    wr(ad(IDX_CTRL_ONE), 32'h1c0, 4'h3, RESP_OKAY);
    // Low byte only: bit 8 of the class D code must survive
    wr(ad(IDX_CTRL_ONE), 32'h0, 4'h1, RESP_OKAY);
    rd(ad(IDX_CTRL_ONE), 32'h100, RESP_OKAY, "byte strobe");
  endtask : t_bus

  // Low enable freezes the dividers and refuses bus beats
  task automatic t_hold();
    logic spk;
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    spk = speaker_switch;
    // Class D ratio 6 here: a live divider would toggle five times
    repeat (30) @(negedge clk);
    check("frozen speaker", speaker_switch, spk);
    check("stalled ready", s_axi_arready, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_hold

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    adc_rate_tick = 1'b0;
    dac_divider_tick = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_gate();
    t_div();
    t_auto();
    t_bus();
    t_hold();
    test_done();
  end
endmodule : acd_clock_dividers_bench
